// ### src/ccrs_pkg.sv
package ccrs_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          RST_HOLD_NS   = 1000;
  localparam logic [7:0]  HOLD_CYC      = 8'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0]  OFF_CORE_RST  = 8'h00;
  localparam logic [7:0]  OFF_CLK_EN    = 8'h04;
  localparam logic [7:0]  OFF_BYPASS    = 8'h08;
  localparam logic [7:0]  OFF_CLK_SEL   = 8'h0C;
  localparam logic [7:0]  OFF_CORE_TGT  = 8'h10;
  localparam logic [7:0]  OFF_TRACE_CFG = 8'h14;
  localparam logic [7:0]  OFF_STATUS    = 8'h18;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          POS_CLK_STOP  = 0;
  localparam int          POS_CLK_START = 1;
  localparam int          POS_DIV_LSB   = 8;
  localparam logic [2:0]  CORE_BITS_RST = 3'h7;
  localparam logic [1:0]  SRC_OSC       = 2'h0;
  localparam logic [7:0]  DIV_RST       = 8'h01;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Synchroniser lanes
  localparam int          SY_DBG        = 0;
  localparam int          SY_SCOLD      = 1;
  localparam int          SY_SWARM      = 2;
  localparam int          SY_CCOLD      = 3;
  localparam int          SY_CWARM      = 4;

  // ----------------------------------------
  // Sequencer states, one-hot; higher code = higher priority
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_CWARM = 5'b00010,
    ST_CCOLD = 5'b00100,
    ST_WARM  = 5'b01000,
    ST_COLD  = 5'b10000
  } ccrs_state_t;

  // ----------------------------------------
  // Whole state of the block
  // ----------------------------------------
  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    ccrs_state_t state;
    logic [7:0]  hold;
    logic        dbg_keep;
    logic [1:0]  rst_core;
    logic [2:0]  core_bits;
    logic        clk_run;
    logic        bypass;
    logic [1:0]  src_sel;
    logic [7:0]  freq_div;
    logic [1:0]  core_tgt;
    logic        trace_cfg;
    logic [1:0]  div_cnt;
    logic        half_tick;
    logic        quarter_tick;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        aw_priv;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ccrs_st_t;

endpackage : ccrs_pkg

// ### src/ccrs_top.sv
// How it works
// [RQ1] Cold or warm reset ends with the boot core released automatically.
// [RQ2] Cold or warm reset sets all three secondary core reset bits.
// [RQ3] Software clears a core reset bit; that core's reset then drops.
// [RQ4] Cold reset resets the whole cluster including debug.
// [RQ5] Warm reset resets everything except debug logic.
// [RQ6] Trace macrocell reset by cold reset only, never by warm reset.
// [RQ7] After trace reset, no trace output until software reconfigures it.
// [RQ8] Cluster clock enable reads 1 on leaving reset.
// [RQ9] Privileged write of 1 to clock stop bit stops cluster clocks.
// [RQ10] Cluster runs from internal oscillator after reset until reselected.
// [RQ11] Source select accepted only under bypass; device follows the selection.
// [RQ12] Half-rate clock enable runs at one half of core rate.
// [RQ13] Quarter-rate clock enable runs at one quarter of core rate.
// [RQ14] Debug-domain signals are synchronised before cluster logic uses them.
// [RQ15] Plain system cold reset: cluster held in reset and powered down.
// [RQ16] Cold reset with debug: cores and L2 in reset, L2 powered, debug on.
// [RQ17] Single-core cold with debug: that core in reset, L2 and debug released.
// [RQ18] Single-core warm with trace: that core in reset, debug active.
// [RQ19] Each secondary core reset bit acts independently of the others.
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
module ccrs_top
  import ccrs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        sys_cold_req,
  input  wire logic        sys_warm_req,
  input  wire logic        core_cold_req,
  input  wire logic        core_warm_req,
  input  wire logic        dbg_active,
  output logic [3:0]       core_rst,
  output logic [3:0]       core_pwr_on,
  output logic             cluster_pwr_on,
  output logic             l2_rst,
  output logic             l2_pwr_on,
  output logic             dbg_rst,
  output logic             trace_rst,
  output logic             trace_out_en,
  output logic             clk_core_en,
  output logic             clk_half_en,
  output logic             clk_quarter_en,
  output logic [1:0]       clk_src_sel,
  output logic [7:0]       clk_freq_div
);
  import ccrs_pkg::*;

  localparam ccrs_st_t ST_INIT = '{state: ST_COLD, hold: HOLD_CYC, core_bits: CORE_BITS_RST,
                                  clk_run: 1'b1, src_sel: SRC_OSC, freq_div: DIV_RST, default: '0};

  ccrs_st_t    st_reg;
  ccrs_st_t    st_next;
  ccrs_state_t req_state;
  logic        wr_go;
  logic        req_none;
  logic [3:0]  tgt_onehot;
  logic [3:0]  sec_rst;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One-hot of a core index
  function automatic logic [3:0] core_hot(input logic [1:0] idx);
    core_hot = 4'h1 << idx;
  endfunction : core_hot

  // Register read mux
  function automatic logic [31:0] rd_word(input ccrs_st_t s, input logic [7:0] a, input logic [3:0] cr);
    rd_word = 32'h0;
    unique case (a)
      OFF_CORE_RST:  rd_word[3:0] = cr;
      OFF_CLK_EN:    rd_word[0] = s.clk_run;
      OFF_BYPASS:    rd_word[0] = s.bypass;
      OFF_CLK_SEL:   rd_word = {16'h0, s.freq_div, 6'h0, s.src_sel};
      OFF_CORE_TGT:  rd_word[1:0] = s.core_tgt;
      OFF_TRACE_CFG: rd_word[0] = s.trace_cfg;
      OFF_STATUS:    rd_word = {24'h0, s.rst_core, s.dbg_keep, s.state};
      default:       rd_word = 32'h0;
    endcase
  endfunction : rd_word

  // Known register offsets
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_CORE_RST) || (a == OFF_CLK_EN) || (a == OFF_BYPASS) || (a == OFF_CLK_SEL)
          || (a == OFF_CORE_TGT) || (a == OFF_TRACE_CFG) || (a == OFF_STATUS);
  endfunction : mapped

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  assign awready  = !st_reg.aw_hold && !st_reg.bvalid;
  assign wready   = !st_reg.w_hold && !st_reg.bvalid;
  assign arready  = !st_reg.rvalid;
  assign wr_go    = st_reg.aw_hold && st_reg.w_hold;
  assign req_none = (st_reg.sync2[SY_CWARM:SY_SCOLD] == 4'h0);

  // Requested reset class, highest priority first
  assign req_state = st_reg.sync2[SY_SCOLD] ? ST_COLD  :
                     st_reg.sync2[SY_SWARM] ? ST_WARM  :
                     st_reg.sync2[SY_CCOLD] ? ST_CCOLD :
                     st_reg.sync2[SY_CWARM] ? ST_CWARM : ST_RUN; // RQ14

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // Two-stage synchronisers on pins and debug domain
    st_next.sync1 = {core_warm_req, core_cold_req, sys_warm_req, sys_cold_req, dbg_active}; // RQ14
    st_next.sync2 = st_reg.sync1; // RQ14
    // Capture address and data in either order
    if (awvalid && awready) begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = awaddr;
      st_next.aw_priv = awprot[0];
    end
    if (wvalid && wready) begin
      st_next.w_hold = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    // Register write once both halves are held
    if (wr_go) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = mapped(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (st_reg.aw_addr)
        OFF_CORE_RST: begin
          if (st_reg.w_strb[0]) begin
            st_next.core_bits = st_reg.w_data[3:1]; // RQ3 RQ19
          end
        end
        OFF_CLK_EN: begin
          if (!st_reg.aw_priv) begin
            st_next.bresp = RESP_SLVERR;
          end else if (st_reg.w_strb[0] && st_reg.w_data[POS_CLK_STOP]) begin
            st_next.clk_run = 1'b0; // RQ9
          end else if (st_reg.w_strb[0] && st_reg.w_data[POS_CLK_START]) begin
            st_next.clk_run = 1'b1;
          end
        end
        OFF_BYPASS: begin
          if (st_reg.w_strb[0]) begin
            st_next.bypass = st_reg.w_data[0];
          end
        end
        OFF_CLK_SEL: begin
          if (!st_reg.bypass) begin
            st_next.bresp = RESP_SLVERR; // RQ11
          end else begin
            if (st_reg.w_strb[0]) begin
              st_next.src_sel = st_reg.w_data[1:0]; // RQ11
            end
            if (st_reg.w_strb[1]) begin
              st_next.freq_div = st_reg.w_data[POS_DIV_LSB +: 8];
            end
          end
        end
        OFF_CORE_TGT: begin
          if (st_reg.w_strb[0]) begin
            st_next.core_tgt = st_reg.w_data[1:0];
          end
        end
        OFF_TRACE_CFG: begin
          if (st_reg.w_strb[0]) begin
            st_next.trace_cfg = st_reg.w_data[0]; // RQ7
          end
        end
        default: begin
        end
      endcase
    end
    // Register read, answered one cycle after the address
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word(st_reg, araddr, core_rst);
      st_next.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // Clock ratio divider, counting only while the group runs
    st_next.half_tick    = st_reg.clk_run && st_reg.div_cnt[0]; // RQ12
    st_next.quarter_tick = st_reg.clk_run && (st_reg.div_cnt == 2'h3); // RQ13
    if (st_reg.clk_run) begin
      st_next.div_cnt = st_reg.div_cnt + 2'h1;
    end
    // Reset sequencing; hardware set wins over software write
    if ((req_state != ST_RUN) && (req_state >= st_reg.state)) begin
      st_next.state    = req_state;
      st_next.hold     = HOLD_CYC;
      st_next.dbg_keep = st_reg.sync2[SY_DBG];
      if (st_reg.state != req_state) begin
        st_next.rst_core = st_reg.core_tgt;
      end
    end else if (st_reg.state != ST_RUN) begin
      if (st_reg.hold != 8'h0) begin
        st_next.hold = st_reg.hold - 8'h1;
      end else begin
        st_next.state = ST_RUN; // RQ1
      end
    end
    if (st_next.state inside {ST_COLD, ST_WARM}) begin
      st_next.core_bits = CORE_BITS_RST; // RQ2
      st_next.clk_run   = 1'b1; // RQ8
      st_next.bypass    = 1'b0;
      st_next.src_sel   = SRC_OSC; // RQ10
      st_next.freq_div  = DIV_RST;
    end
    if (st_next.state == ST_COLD) begin
      st_next.trace_cfg = 1'b0; // RQ6 RQ7
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Reset and power outputs per state
  // ----------------------------------------
  assign tgt_onehot = core_hot(st_reg.rst_core);
  assign sec_rst    = {st_reg.core_bits, 1'b0}; // RQ19

  always_comb begin
    core_rst       = sec_rst; // RQ1 RQ3
    core_pwr_on    = 4'hF;
    cluster_pwr_on = 1'b1;
    l2_rst         = 1'b0;
    l2_pwr_on      = 1'b1;
    dbg_rst        = 1'b0;
    trace_rst      = 1'b0;
    unique case (st_reg.state)
      ST_RUN: begin
      end
      ST_COLD: begin
        core_rst       = 4'hF; // RQ4 RQ16
        l2_rst         = 1'b1;
        trace_rst      = 1'b1; // RQ6
        dbg_rst        = !st_reg.dbg_keep; // RQ4 RQ16
        cluster_pwr_on = st_reg.dbg_keep; // RQ15
        l2_pwr_on      = st_reg.dbg_keep; // RQ15 RQ16
        core_pwr_on    = st_reg.dbg_keep ? 4'hF : 4'h0;
      end
      ST_WARM: begin
        core_rst = 4'hF; // RQ5
        l2_rst   = 1'b1;
      end
      ST_CCOLD, ST_CWARM: begin
        core_rst = sec_rst | tgt_onehot; // RQ17 RQ18
      end
    endcase
  end

  // ----------------------------------------
  // Clock and bus outputs
  // ----------------------------------------
  assign trace_out_en   = st_reg.trace_cfg && !trace_rst; // RQ7
  assign clk_core_en    = st_reg.clk_run; // RQ9
  assign clk_half_en    = st_reg.half_tick; // RQ12
  assign clk_quarter_en = st_reg.quarter_tick; // RQ13
  assign clk_src_sel    = st_reg.bypass ? SRC_OSC : st_reg.src_sel; // RQ10 RQ11
  assign clk_freq_div   = st_reg.freq_div;
  assign bvalid         = st_reg.bvalid;
  assign bresp          = st_reg.bresp;
  assign rvalid         = st_reg.rvalid;
  assign rdata          = st_reg.rdata;
  assign rresp          = st_reg.rresp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_sys_exit;
    (st_reg.state inside {ST_COLD, ST_WARM}) ##1 (st_reg.state == ST_RUN);
  endsequence
  property p_boot_free;
    st_reg.state == ST_RUN |-> !core_rst[0];
  endproperty
  a_boot_free: assert property (p_boot_free) else $error("boot core held in run"); // RQ1
  property p_sec_held;
    s_sys_exit |-> core_rst[3:1] == 3'h7;
  endproperty
  a_sec_held: assert property (p_sec_held) else $error("secondary released by reset"); // RQ2
  property p_release;
    (wr_go && st_reg.aw_addr == OFF_CORE_RST && st_reg.w_strb[0] && st_reg.state == ST_RUN && req_none)
      |=> core_rst[3:1] == $past(st_reg.w_data[3:1]);
  endproperty
  a_release: assert property (p_release) else $error("core bit write not followed"); // RQ3
  property p_cold_all;
    (st_reg.state == ST_COLD && !st_reg.dbg_keep) |-> dbg_rst && l2_rst && core_rst == 4'hF;
  endproperty
  a_cold_all: assert property (p_cold_all) else $error("cold reset incomplete"); // RQ4
  property p_warm;
    st_reg.state == ST_WARM |-> !dbg_rst && !trace_rst && core_rst == 4'hF;
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset touched debug"); // RQ5
  property p_trace_quiet;
    trace_rst ##1 !trace_rst |-> !trace_out_en;
  endproperty
  a_trace_quiet: assert property (p_trace_quiet) else $error("trace out after reset"); // RQ7
  property p_clk_after;
    s_sys_exit |-> clk_core_en && clk_src_sel == SRC_OSC;
  endproperty
  a_clk_after: assert property (p_clk_after) else $error("clock state after reset"); // RQ8
  property p_stop;
    (wr_go && st_reg.aw_addr == OFF_CLK_EN && st_reg.aw_priv && st_reg.w_strb[0]
      && st_reg.w_data[POS_CLK_STOP] && req_none) |=> !clk_core_en ##1 !clk_half_en;
  endproperty
  a_stop: assert property (p_stop) else $error("clock not stopped"); // RQ9
  property p_quarter;
    clk_quarter_en |-> clk_half_en ##1 !clk_quarter_en [*3];
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter rate wrong"); // RQ13
  property p_half;
    (clk_half_en && clk_core_en) ##1 clk_core_en |=> clk_half_en;
  endproperty
  a_half: assert property (p_half) else $error("half rate wrong"); // RQ12
  property p_cold_dbg;
    (st_reg.state == ST_COLD) |-> (st_reg.dbg_keep == (l2_pwr_on && !dbg_rst && cluster_pwr_on));
  endproperty
  a_cold_dbg: assert property (p_cold_dbg) else $error("cold power or debug wrong"); // RQ15 RQ16
  property p_core_rst;
    (st_reg.state inside {ST_CCOLD, ST_CWARM}) |-> |(core_rst & tgt_onehot) && !dbg_rst && !l2_rst;
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("single core reset wrong"); // RQ17 RQ18

  c_release: cover property (s_sys_exit ##[1:200] core_rst[1] == 1'b0);
  c_core_cold: cover property (st_reg.state == ST_CCOLD ##[1:100] st_reg.state == ST_RUN);
  c_src_change: cover property (st_reg.bypass ##[1:50] clk_src_sel != SRC_OSC);

endmodule : ccrs_top

// ### tb/tb_top.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top
  import ccrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic        bready = 1'h1, rready = 1'h1, dbg_active = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, clk_freq_div;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0, req = 4'h0, core_rst, core_pwr_on;
  logic [1:0]  bresp, rresp, clk_src_sel;
  logic        awready, wready, bvalid, arready, rvalid, cluster_pwr_on, l2_rst, l2_pwr_on;
  logic        dbg_rst, trace_rst, trace_out_en, clk_core_en, clk_half_en, clk_quarter_en;
  int          fails = 0, num_checks = 0, cyc = 0;

  ccrs_top dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sys_cold_req(req[0]), .sys_warm_req(req[1]), .core_cold_req(req[2]),
    .core_warm_req(req[3]), .dbg_active(dbg_active), .core_rst(core_rst),
    .core_pwr_on(core_pwr_on), .cluster_pwr_on(cluster_pwr_on), .l2_rst(l2_rst),
    .l2_pwr_on(l2_pwr_on), .dbg_rst(dbg_rst), .trace_rst(trace_rst), .trace_out_en(trace_out_en),
    .clk_core_en(clk_core_en), .clk_half_en(clk_half_en), .clk_quarter_en(clk_quarter_en),
    .clk_src_sel(clk_src_sel), .clk_freq_div(clk_freq_div)
  );

  // Bench clock
  always #25 aclk = ~aclk;

  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // Bus write, response compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'h0;
    w_done  = 1'h0;
    awaddr  <= a;
    awprot  <= p;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'h1) begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_done && wready === 1'h1) begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    `CHK(bresp, er)
  endtask : wr

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arprot  <= 3'h1;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
  endtask : rd

  // Reset pin raise and drop
  task automatic pin(input int k);
    req[k] <= 1'h1;
    tick(6);
  endtask : pin

  task automatic unpin(input int k);
    req[k] <= 1'h0;
    tick(30);
  endtask : unpin

  // Pulse counts over eight cycles
  task automatic cnt(output logic [3:0] h, output logic [3:0] q);
    h = 4'h0;
    q = 4'h0;
    repeat (8) begin
      @(posedge aclk);
      h = h + 4'(clk_half_en);
      q = q + 4'(clk_quarter_en);
    end
  endtask : cnt

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    tick(1);
    `CHK(core_rst, 4'hF)
    `CHK(cluster_pwr_on, 1'h0)
    `CHK(clk_core_en, 1'h1)
    `CHK(clk_src_sel, SRC_OSC)
    `CHK(dbg_rst, 1'h1)
    `CHK(trace_rst, 1'h1)
    `CHK(core_pwr_on, 4'h0)
    tick(25);
    `CHK(core_rst, 4'hE)
    `CHK(core_rst[3:1], 3'h7)
    `CHK(dbg_rst, 1'h0)
  endtask : t_reset

  task automatic t_cores();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_CORE_RST, 32'hC, 3'h1, RESP_OKAY);
    tick(1);
    `CHK(core_rst, 4'hC)
    rd(OFF_CORE_RST, d, r);
    `CHK(d, 32'hC)
    wr(OFF_CORE_RST, 32'h0, 3'h1, RESP_OKAY);
    tick(1);
    `CHK(core_rst, 4'h0)
    rd(8'h40, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0)
    rd(OFF_STATUS, d, r);
    `CHK(d, 32'h01)
    `CHK(r, RESP_OKAY)
  endtask : t_cores

  task automatic t_clock();
    logic [3:0] h, q;
    wr(OFF_CLK_EN, 32'h1, 3'h0, RESP_SLVERR);
    tick(1);
    `CHK(clk_core_en, 1'h1)
    wr(OFF_CLK_EN, 32'h1, 3'h1, RESP_OKAY);
    tick(1);
    `CHK(clk_core_en, 1'h0)
    cnt(h, q);
    `CHK(h, 4'h0)
    wr(OFF_CLK_EN, 32'h2, 3'h1, RESP_OKAY);
    tick(2);
    cnt(h, q);
    `CHK(h, 4'h4)
    `CHK(q, 4'h2)
  endtask : t_clock

  task automatic t_source();
    wr(OFF_CLK_SEL, 32'h0502, 3'h1, RESP_SLVERR);
    tick(1);
    `CHK(clk_freq_div, DIV_RST)
    wr(OFF_BYPASS, 32'h1, 3'h1, RESP_OKAY);
    wr(OFF_CLK_SEL, 32'h0502, 3'h1, RESP_OKAY);
    tick(1);
    `CHK(clk_src_sel, SRC_OSC)
    `CHK(clk_freq_div, 8'h05)
    wr(OFF_BYPASS, 32'h0, 3'h1, RESP_OKAY);
    tick(1);
    `CHK(clk_src_sel, 2'h2)
  endtask : t_source

  task automatic t_warm();
    wr(OFF_TRACE_CFG, 32'h1, 3'h1, RESP_OKAY);
    pin(1);
    `CHK(core_rst, 4'hF)
    `CHK(dbg_rst, 1'h0)
    `CHK(trace_rst, 1'h0)
    unpin(1);
    `CHK(core_rst, 4'hE)
    `CHK(trace_out_en, 1'h1)
  endtask : t_warm

  task automatic t_cold();
    dbg_active <= 1'h1;
    pin(0);
    `CHK(core_rst, 4'hF)
    `CHK(l2_rst, 1'h1)
    `CHK(l2_pwr_on, 1'h1)
    `CHK(core_pwr_on, 4'hF)
    `CHK(dbg_rst, 1'h0)
    `CHK(trace_rst, 1'h1)
    unpin(0);
    `CHK(trace_out_en, 1'h0)
    dbg_active <= 1'h0;
    tick(3);
    pin(0);
    `CHK(cluster_pwr_on, 1'h0)
    `CHK(l2_pwr_on, 1'h0)
    `CHK(core_pwr_on, 4'h0)
    `CHK(core_rst, 4'hF)
    `CHK(dbg_rst, 1'h1)
    unpin(0);
    `CHK(core_rst, 4'hE)
  endtask : t_cold

  task automatic t_single();
    logic [31:0] d;
    logic [1:0]  r;
    dbg_active <= 1'h1;
    wr(OFF_CORE_RST, 32'h0, 3'h1, RESP_OKAY);
    wr(OFF_CORE_TGT, 32'h2, 3'h1, RESP_OKAY);
    pin(2);
    `CHK(core_rst, 4'h4)
    `CHK(l2_rst, 1'h0)
    `CHK(dbg_rst, 1'h0)
    `CHK(core_pwr_on, 4'hF)
    rd(OFF_STATUS, d, r);
    `CHK(d, 32'hA4)
    unpin(2);
    wr(OFF_CORE_RST, 32'h0, 3'h1, RESP_OKAY);
    wr(OFF_CORE_TGT, 32'h3, 3'h1, RESP_OKAY);
    pin(3);
    `CHK(core_rst, 4'h8)
    `CHK(dbg_rst, 1'h0)
    unpin(3);
  endtask : t_single

  // Main sequence
  initial begin
    tick(6);
    aresetn <= 1'h1;
    t_reset();
    t_cores();
    t_clock();
    t_source();
    t_warm();
    t_cold();
    t_single();
    wrap_up();
  end
endmodule : tb_top
